// ### logic/stop_reaction_regs.svh
`ifndef STOP_REACTION_REGS_SVH
`define STOP_REACTION_REGS_SVH

// =====================================================================
// Object indices
`define IDX_QUICK_STOP    16'h605a
`define IDX_SHUTDOWN      16'h605b
`define IDX_DISABLE_OP    16'h605c
`define IDX_HALT          16'h605d
`define IDX_FAULT         16'h605e

// =====================================================================
// Reset values
`define RST_QUICK_STOP    16'h0002
`define RST_SHUTDOWN      16'h0001
`define RST_DISABLE_OP    16'h0001
`define RST_HALT          16'h0001
`define RST_FAULT         16'h0002

// =====================================================================
// Option code values
`define CODE_0            16'h0000
`define CODE_1            16'h0001
`define CODE_2            16'h0002
`define CODE_5            16'h0005
`define CODE_6            16'h0006

// =====================================================================
// Halt bit position in the controlword
`define CW_HALT_BIT       8

`endif

// ### logic/stop_reaction_pkg.sv
package stop_reaction_pkg;

    typedef enum logic [1:0] {
        REACT_IMMEDIATE,
        REACT_SLOW_RAMP,
        REACT_QUICK_RAMP,
        REACT_COAST
    } reaction_t;

    typedef enum logic [2:0] {
        PS_NONE,
        PS_SWITCH_ON_DISABLED,
        PS_READY_TO_SWITCH_ON,
        PS_SWITCHED_ON,
        PS_QUICK_STOP_ACTIVE,
        PS_FAULT_STOP
    } follow_state_t;

    typedef enum logic [2:0] {
        TRG_QUICK_STOP,
        TRG_SHUTDOWN,
        TRG_DISABLE_OP,
        TRG_HALT,
        TRG_FAULT
    } trigger_t;

endpackage

// ### logic/option_bus_if.sv
`timescale 1ns/1ps
interface option_bus_if;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [15:0] wr_data;
    logic [2:0]  rd_sel;
    logic [15:0] rd_data;
    logic [79:0] codes;

    modport ctrl (output wr_en, output wr_sel, output wr_data, output rd_sel,
                  input rd_data, input codes);
    modport store (input wr_en, input wr_sel, input wr_data, input rd_sel,
                   output rd_data, output codes);
endinterface

// ### logic/option_code_store.sv
`timescale 1ns/1ps
`include "stop_reaction_regs.svh"
module option_code_store
    import stop_reaction_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   arst_n,
    option_bus_if.store bus
);

    typedef struct packed {
        logic [4:0][15:0] code;
        logic [15:0]      rd;
    } store_state_t;

    store_state_t st_r;
    store_state_t st_nxt;

    localparam logic [4:0][15:0] RST_CODES = {`RST_FAULT, `RST_HALT, `RST_DISABLE_OP,
                                              `RST_SHUTDOWN, `RST_QUICK_STOP};

    // =================================================================
    // Code storage with registered read data
    always_comb begin
        st_nxt = st_r;
        if (bus.wr_en && bus.wr_sel <= 3'd4) begin
            st_nxt.code[bus.wr_sel] = bus.wr_data;
        end
        // Read data is captured only on a read and then held for the master
        if (bus.rd_sel <= 3'd4) begin
            st_nxt.rd = st_nxt.code[bus.rd_sel];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{code: RST_CODES, rd: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.rd_data = st_r.rd;
    assign bus.codes   = st_r.code;

endmodule

// ### logic/drive_stop_reaction_select.sv
// Contract
// - Quick stop code 0: immediate stop, switch-on-disabled
// - Quick stop code 1: slow ramp, switch-on-disabled
// - Quick stop code 2: quick ramp, switch-on-disabled
// - Shutdown code 1: slow ramp, ready-to-switch-on
// - Disable code 1: slow ramp, switched-on
// - Shutdown or disable code 0: coast freely
// - Halt bit set runs halt code reaction
// - Halt code 1 slow, 2 quick, others reserved
// - Fault brings motor to standstill per code
// - Fault code 0 coast, 1 slow, 2 quick
//
`timescale 1ns/1ps
`include "stop_reaction_regs.svh"
module drive_stop_reaction_select
    import stop_reaction_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        obj_wr,
    input  wire logic        obj_rd,
    input  wire logic [15:0] obj_index,
    input  wire logic [15:0] obj_wdata,
    output logic      [15:0] obj_rdata,
    output logic             obj_ack,
    output logic             obj_err,
    input  wire logic        quick_stop_req,
    input  wire logic        shutdown_req,
    input  wire logic        disable_op_req,
    input  wire logic        fault_req,
    input  wire logic [15:0] controlword,
    input  wire logic        ramp_done,
    output logic             react_active,
    output reaction_t        react_kind,
    output logic             drive_enable,
    output follow_state_t    follow_state,
    output logic             follow_valid
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_HOLD
    } fsm_t;

    typedef struct packed {
        fsm_t          fsm;
        reaction_t     kind;
        follow_state_t follow;
        logic          halt_run;
        logic          out_active;
        logic          out_enable;
        follow_state_t out_state;
        logic          out_valid;
        logic          ack;
        logic          err;
        logic          rd_pend;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    option_bus_if bus ();

    option_code_store i_option_code_store (
        .clk    (clk),
        .arst_n (arst_n),
        .bus    (bus)
    );

    logic [15:0] qs_code;
    logic [15:0] sd_code;
    logic [15:0] dis_code;
    logic [15:0] halt_code;
    logic [15:0] flt_code;
    logic        halt_bit;
    logic [2:0]  sel;
    logic        sel_ok;
    logic        val_ok;

    assign qs_code   = bus.codes[15:0];
    assign sd_code   = bus.codes[31:16];
    assign dis_code  = bus.codes[47:32];
    assign halt_code = bus.codes[63:48];
    assign flt_code  = bus.codes[79:64];
    assign halt_bit  = controlword[`CW_HALT_BIT];

    // =================================================================
    // Object index decode and value check
    always_comb begin
        sel    = 3'd7;
        sel_ok = 1'b1;
        val_ok = 1'b0;
        if (obj_index == `IDX_QUICK_STOP) begin
            sel    = 3'd0;
            val_ok = obj_wdata == `CODE_0 || obj_wdata == `CODE_1 || obj_wdata == `CODE_2 ||
                     obj_wdata == `CODE_5 || obj_wdata == `CODE_6;
        end else if (obj_index == `IDX_SHUTDOWN) begin
            sel    = 3'd1;
            val_ok = obj_wdata == `CODE_0 || obj_wdata == `CODE_1;
        end else if (obj_index == `IDX_DISABLE_OP) begin
            sel    = 3'd2;
            val_ok = obj_wdata == `CODE_0 || obj_wdata == `CODE_1;
        end else if (obj_index == `IDX_HALT) begin
            sel    = 3'd3;
            val_ok = obj_wdata == `CODE_1 || obj_wdata == `CODE_2;
        end else if (obj_index == `IDX_FAULT) begin
            sel    = 3'd4;
            val_ok = obj_wdata == `CODE_0 || obj_wdata == `CODE_1 || obj_wdata == `CODE_2;
        end else begin
            sel_ok = 1'b0;
        end
    end

    assign bus.wr_en   = obj_wr && sel_ok && val_ok;
    assign bus.wr_sel  = sel;
    assign bus.wr_data = obj_wdata;
    assign bus.rd_sel  = (obj_rd && !obj_wr) ? sel : 3'd7;

    // =================================================================
    // Reaction sequencer
    always_comb begin
        st_nxt          = st_r;
        st_nxt.ack      = 1'b0;
        st_nxt.err      = 1'b0;
        st_nxt.rd_pend  = 1'b0;
        st_nxt.out_valid = 1'b0;

        if (obj_wr) begin
            st_nxt.ack = sel_ok && val_ok;
            st_nxt.err = !(sel_ok && val_ok);
        end else if (obj_rd) begin
            if (sel_ok) begin
                st_nxt.rd_pend = 1'b1;
            end else begin
                st_nxt.err = 1'b1;
            end
        end
        if (st_r.rd_pend) begin
            st_nxt.ack = 1'b1;
        end

        case (st_r.fsm)
            ST_IDLE: begin
                // Priority: fault, quick stop, shutdown, disable, halt
                if (fault_req) begin
                    st_nxt.fsm    = ST_RUN;
                    st_nxt.follow = PS_FAULT_STOP;
                    if (flt_code == `CODE_0) begin
                        st_nxt.kind = REACT_COAST;
                    end else if (flt_code == `CODE_1) begin
                        st_nxt.kind = REACT_SLOW_RAMP;
                    end else begin
                        st_nxt.kind = REACT_QUICK_RAMP;
                    end
                end else if (quick_stop_req) begin
                    st_nxt.fsm    = ST_RUN;
                    st_nxt.follow = PS_SWITCH_ON_DISABLED;
                    if (qs_code == `CODE_0) begin
                        st_nxt.kind = REACT_IMMEDIATE;
                    end else if (qs_code == `CODE_1) begin
                        st_nxt.kind = REACT_SLOW_RAMP;
                    end else if (qs_code == `CODE_5) begin
                        st_nxt.kind   = REACT_SLOW_RAMP;
                        st_nxt.follow = PS_QUICK_STOP_ACTIVE;
                    end else if (qs_code == `CODE_6) begin
                        st_nxt.kind   = REACT_QUICK_RAMP;
                        st_nxt.follow = PS_QUICK_STOP_ACTIVE;
                    end else begin
                        st_nxt.kind = REACT_QUICK_RAMP;
                    end
                end else if (shutdown_req) begin
                    st_nxt.fsm    = ST_RUN;
                    st_nxt.follow = PS_READY_TO_SWITCH_ON;
                    st_nxt.kind   = (sd_code == `CODE_0) ? REACT_COAST
                                                         : REACT_SLOW_RAMP;
                end else if (disable_op_req) begin
                    st_nxt.fsm    = ST_RUN;
                    st_nxt.follow = PS_SWITCHED_ON;
                    st_nxt.kind   = (dis_code == `CODE_0) ? REACT_COAST
                                                          : REACT_SLOW_RAMP;
                end else if (halt_bit) begin
                    st_nxt.fsm      = ST_RUN;
                    st_nxt.follow   = PS_NONE;
                    st_nxt.halt_run = 1'b1;
                    st_nxt.kind     = (halt_code == `CODE_2) ? REACT_QUICK_RAMP
                                                             : REACT_SLOW_RAMP;
                end
                st_nxt.out_active = st_nxt.fsm == ST_RUN;
                st_nxt.out_enable = !(st_nxt.fsm == ST_RUN &&
                                      (st_nxt.kind == REACT_COAST ||
                                       st_nxt.kind == REACT_IMMEDIATE));
            end
            ST_RUN: begin
                // Immediate stop and coasting finish at once
                if (ramp_done || st_r.kind == REACT_IMMEDIATE || st_r.kind == REACT_COAST) begin
                    st_nxt.out_active = 1'b0;
                    st_nxt.out_state  = st_r.follow;
                    st_nxt.out_valid  = !st_r.halt_run;
                    st_nxt.out_enable = st_r.follow == PS_QUICK_STOP_ACTIVE ||
                                        st_r.halt_run;
                    st_nxt.fsm        = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Wait for the cause to drop before re-arming
                if (!fault_req && !quick_stop_req && !shutdown_req &&
                    !disable_op_req && !halt_bit) begin
                    st_nxt.fsm        = ST_IDLE;
                    st_nxt.halt_run   = 1'b0;
                    st_nxt.out_enable = 1'b1;
                end
            end
            default: st_nxt.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{fsm: ST_IDLE, kind: REACT_IMMEDIATE, follow: PS_NONE,
                      halt_run: 1'b0, out_active: 1'b0, out_enable: 1'b1,
                      out_state: PS_NONE, out_valid: 1'b0, ack: 1'b0,
                      err: 1'b0, rd_pend: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // =================================================================
    // Outputs
    assign obj_rdata    = bus.rd_data;
    assign obj_ack      = st_r.ack;
    assign obj_err      = st_r.err;
    assign react_active = st_r.out_active;
    assign react_kind   = st_r.kind;
    assign drive_enable = st_r.out_enable;
    assign follow_state = st_r.out_state;
    assign follow_valid = st_r.out_valid;

    // =================================================================
    // Assertions
    property p_bad_write_kept;
        @(posedge clk) disable iff (!arst_n)
        (obj_wr && !(sel_ok && val_ok)) |=> $stable(bus.codes) && obj_err;
    endproperty
    a_bad_write_kept: assert property (p_bad_write_kept) else $error("reserved write stored");

    property p_qs0_immediate;
        @(posedge clk) disable iff (!arst_n)
        (st_r.fsm == ST_IDLE && !fault_req && quick_stop_req && qs_code == `CODE_0)
        |=> react_kind == REACT_IMMEDIATE ##1 follow_valid &&
            follow_state == PS_SWITCH_ON_DISABLED;
    endproperty
    a_qs0_immediate: assert property (p_qs0_immediate) else $error("qs code 0 wrong");

    property p_qs_stay;
        @(posedge clk) disable iff (!arst_n)
        (follow_valid && follow_state == PS_QUICK_STOP_ACTIVE) |-> drive_enable;
    endproperty
    a_qs_stay: assert property (p_qs_stay) else $error("motor de-energised in qs active");

    property p_coast;
        @(posedge clk) disable iff (!arst_n)
        (st_r.fsm == ST_IDLE && !fault_req && !quick_stop_req && shutdown_req &&
         sd_code == `CODE_0) |=> react_kind == REACT_COAST && !drive_enable;
    endproperty
    a_coast: assert property (p_coast) else $error("shutdown code 0 not coasting");

    property p_halt_quick;
        @(posedge clk) disable iff (!arst_n)
        (st_r.fsm == ST_IDLE && !fault_req && !quick_stop_req && !shutdown_req &&
         !disable_op_req && halt_bit && halt_code == `CODE_2)
        |=> react_active && react_kind == REACT_QUICK_RAMP;
    endproperty
    a_halt_quick: assert property (p_halt_quick) else $error("halt code 2 wrong");

    property p_wait_ramp;
        @(posedge clk) disable iff (!arst_n)
        (react_active && react_kind == REACT_SLOW_RAMP && !ramp_done) |=> !follow_valid;
    endproperty
    a_wait_ramp: assert property (p_wait_ramp) else $error("follow state before ramp end");

    property p_fault_slow;
        @(posedge clk) disable iff (!arst_n)
        (st_r.fsm == ST_IDLE && fault_req && flt_code == `CODE_1)
        |=> react_kind == REACT_SLOW_RAMP && react_active;
    endproperty
    a_fault_slow: assert property (p_fault_slow) else $error("fault code 1 wrong");

    property p_disable_slow;
        @(posedge clk) disable iff (!arst_n)
        (st_r.fsm == ST_IDLE && !fault_req && !quick_stop_req && !shutdown_req &&
         disable_op_req && dis_code == `CODE_1) ##1 !ramp_done ##1 ramp_done
        |=> follow_valid && follow_state == PS_SWITCHED_ON && react_kind == REACT_SLOW_RAMP;
    endproperty
    a_disable_slow: assert property (p_disable_slow) else $error("disable code 1 wrong");

    c_quick_stop: cover property (@(posedge clk) disable iff (!arst_n)
                                  follow_valid && follow_state == PS_SWITCH_ON_DISABLED);
    c_halt: cover property (@(posedge clk) disable iff (!arst_n) react_active && st_r.halt_run);
    c_reject: cover property (@(posedge clk) disable iff (!arst_n) obj_err);

endmodule

// ### dv/option_master.sv
`timescale 1ns/1ps
// =====================================================================
// Fieldbus master model: one object access per call
module option_master (
    input  wire logic        clk,
    input  wire logic [15:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic      [15:0] obj_index,
    output logic      [15:0] obj_wdata
);
    initial begin
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 16'h0000;
    end

    task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wdata,
                          output logic ack, output logic err, output logic [15:0] rdata);
        int n;
        ack   = 1'b0;
        err   = 1'b0;
        rdata = 16'h0000;
        @(negedge clk);
        obj_wr    = wr;
        obj_rd    = ~wr;
        obj_index = idx;
        obj_wdata = wdata;
        @(negedge clk);
        obj_wr    = 1'b0;
        obj_rd    = 1'b0;
        // Released lines show the inverse so a stale value never passes as live
        obj_index = ~idx;
        obj_wdata = ~wdata;
        for (n = 0; n < 6; n++) begin
            if (obj_ack === 1'b1 || obj_err === 1'b1) begin
                ack   = obj_ack;
                err   = obj_err;
                rdata = obj_rdata;
                break;
            end
            @(negedge clk);
        end
    endtask
endmodule

// ### dv/drive_stop_reaction_select_bench.sv
`timescale 1ns/1ps
`include "stop_reaction_regs.svh"
module drive_stop_reaction_select_bench;
    import stop_reaction_pkg::*;

    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic          obj_wr, obj_rd, obj_ack, obj_err;
    logic [15:0]   obj_index, obj_wdata, obj_rdata;
    logic [3:0]    req = 4'h0;
    logic [15:0]   controlword = 16'h0000;
    logic          ramp_done = 1'b0;
    logic          react_active, drive_enable, follow_valid;
    reaction_t     react_kind;
    follow_state_t follow_state;
    int            failures = 0;
    int            num_checks = 0;

    always #25 clk = ~clk;

    drive_stop_reaction_select i_drive_stop_reaction_select (
        .clk(clk), .arst_n(arst_n), .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .quick_stop_req(req[0]),
        .shutdown_req(req[1]), .disable_op_req(req[2]), .fault_req(req[3]),
        .controlword(controlword), .ramp_done(ramp_done), .react_active(react_active),
        .react_kind(react_kind), .drive_enable(drive_enable),
        .follow_state(follow_state), .follow_valid(follow_valid));

    option_master i_option_master (
        .clk(clk), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata));

    // =================================================================
    // Common tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr_code(input logic [15:0] idx, input logic [15:0] val, input logic exp_err);
        logic a, e;
        logic [15:0] d;
        i_option_master.access(1'b1, idx, val, a, e, d);
        check({14'h0000, a, e}, {14'h0000, ~exp_err, exp_err});
    endtask

    task automatic rd_code(input logic [15:0] idx, input logic [15:0] exp);
        logic a, e;
        logic [15:0] d;
        i_option_master.access(1'b0, idx, 16'h0000, a, e, d);
        check(d, exp);
    endtask

    // Trigger 0 quick stop, 1 shutdown, 2 disable, 3 fault, 4 halt
    task automatic react(input int trg, input reaction_t kind, input follow_state_t fs,
                         input logic en_after, input logic late);
        int n;
        @(negedge clk);
        if (trg == 4)
            controlword = 16'h0100;
        else
            req[trg] = 1'b1;
        for (n = 0; n < 4; n++) begin
            @(negedge clk);
            if (react_active === 1'b1)
                break;
        end
        check({14'h0000, react_kind}, {14'h0000, kind});
        req = 4'h0;
        controlword = 16'h0000;
        if (late)
            wr_code(`IDX_QUICK_STOP, 16'h0005, 1'b0);
        if (kind == REACT_SLOW_RAMP || kind == REACT_QUICK_RAMP) begin
            @(negedge clk);
            ramp_done = 1'b1;
            @(negedge clk);
            ramp_done = 1'b0;
        end
        for (n = 0; n < 8 && react_active !== 1'b0; n++)
            @(negedge clk);
        check({15'h0000, react_active}, 16'h0000);
        check({15'h0000, follow_valid}, {15'h0000, trg != 4});
        if (trg != 4)
            check({13'h0000, follow_state}, {13'h0000, fs});
        check({15'h0000, drive_enable}, {15'h0000, en_after});
        repeat (2) @(negedge clk);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset_values();
        rd_code(`IDX_QUICK_STOP, 16'h0002);
        rd_code(`IDX_SHUTDOWN, 16'h0001);
        rd_code(`IDX_DISABLE_OP, 16'h0001);
        rd_code(`IDX_HALT, 16'h0001);
        rd_code(`IDX_FAULT, 16'h0002);
    endtask

    task automatic t_reserved();
        logic [15:0] idx [6] = '{16'h605a, 16'h605a, 16'h605b, 16'h605c, 16'h605d, 16'h605e};
        logic [15:0] val [6] = '{16'h0003, 16'h8000, 16'h0002, 16'hffff, 16'h0000, 16'h0003};
        logic [15:0] keep [6] = '{16'h0002, 16'h0002, 16'h0001, 16'h0001, 16'h0001, 16'h0002};
        logic a, e;
        logic [15:0] d;
        for (int i = 0; i < 6; i++) begin
            wr_code(idx[i], val[i], 1'b1);
            rd_code(idx[i], keep[i]);
        end
        wr_code(16'h605f, 16'h0001, 1'b1);
        i_option_master.access(1'b0, 16'h605f, 16'h0000, a, e, d);
        check({15'h0000, e}, 16'h0001);
    endtask

    task automatic t_halt();
        react(4, REACT_SLOW_RAMP, PS_NONE, 1'b1, 1'b0);
        wr_code(`IDX_HALT, 16'h0002, 1'b0);
        react(4, REACT_QUICK_RAMP, PS_NONE, 1'b1, 1'b0);
    endtask

    task automatic t_quick_stop();
        logic [15:0] code [5] = '{16'h0005, 16'h0006, 16'h0000, 16'h0001, 16'h0002};
        reaction_t   kind [5] = '{REACT_SLOW_RAMP, REACT_QUICK_RAMP, REACT_IMMEDIATE,
                                  REACT_SLOW_RAMP, REACT_QUICK_RAMP};
        for (int i = 0; i < 5; i++) begin
            wr_code(`IDX_QUICK_STOP, code[i], 1'b0);
            react(0, kind[i], i < 2 ? PS_QUICK_STOP_ACTIVE : PS_SWITCH_ON_DISABLED,
                  i < 2, 1'b0);
        end
    endtask

    task automatic t_shutdown_disable();
        react(1, REACT_SLOW_RAMP, PS_READY_TO_SWITCH_ON, 1'b0, 1'b0);
        react(2, REACT_SLOW_RAMP, PS_SWITCHED_ON, 1'b0, 1'b0);
        wr_code(`IDX_SHUTDOWN, 16'h0000, 1'b0);
        react(1, REACT_COAST, PS_READY_TO_SWITCH_ON, 1'b0, 1'b0);
        wr_code(`IDX_DISABLE_OP, 16'h0000, 1'b0);
        react(2, REACT_COAST, PS_SWITCHED_ON, 1'b0, 1'b0);
    endtask

    task automatic t_fault();
        react(3, REACT_QUICK_RAMP, PS_FAULT_STOP, 1'b0, 1'b0);
        wr_code(`IDX_FAULT, 16'h0001, 1'b0);
        react(3, REACT_SLOW_RAMP, PS_FAULT_STOP, 1'b0, 1'b0);
        wr_code(`IDX_FAULT, 16'h0000, 1'b0);
        react(3, REACT_COAST, PS_FAULT_STOP, 1'b0, 1'b0);
    endtask

    task automatic t_sample_at_start();
        wr_code(`IDX_QUICK_STOP, 16'h0001, 1'b0);
        react(0, REACT_SLOW_RAMP, PS_SWITCH_ON_DISABLED, 1'b0, 1'b1);
        rd_code(`IDX_QUICK_STOP, 16'h0005);
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        t_reset_values();
        t_reserved();
        t_halt();
        t_quick_stop();
        t_shutdown_disable();
        t_fault();
        t_sample_at_start();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
